// *** hdl/plausibility_monitor.sv ***
// Dual sensor plausibility monitor with Wishbone registers
`timescale 1ns/1ns
`default_nettype none
`include "monitor_consts.svh"
module plausibility_monitor #(
  parameter int TICK_CYCLES = `TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] first_sensor_input_i,
  input wire logic [15:0] second_sensor_input_i,
  input wire logic [3:0] range_sel_i,
  output logic enable_o,
  output logic sensor_status_o,
  output logic [3:0] signal_range_o
);
  function automatic logic [15:0] wmerge(input logic [15:0] old,
    input logic [31:0] dat, input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) r[7:0] = dat[7:0];
    if (sel[1]) r[15:8] = dat[15:8];
    return r;
  endfunction

  logic tick;
  logic ack_q, ack_d, wr;
  logic [31:0] dat_q, dat_d;
  logic var_q, var_d, inc_en_q, inc_en_d;
  logic [2:0] cons_q, cons_d;
  logic [5:0] delay_q, delay_d;
  logic [13:0] disc_q, disc_d;
  logic [15:0] perm_q, perm_d, inc_q, inc_d, fmin_q, fmin_d, fmax_q, fmax_d;
  logic [15:1] act_q, act_d;
  logic [15:0] grad_q [2];
  logic [15:0] ofs_q [2];
  logic [15:0] rmin_q [1:15];
  logic [15:0] rmax_q [1:15];
  logic [15:0] cur [2];
  logic bad [2];
  monitor_pkg::value_t norm [2];
  monitor_pkg::value_t v1, v2, pv, cur_min, cur_max;
  logic signed [16:0] dsig;
  logic [16:0] adiff, five;
  logic over_perm, below_perm, over_inc, inc_on, sens_ok, rng_ok, near_ok;
  logic [13:0] rst_ticks, dcnt_q, dcnt_d, rcnt_q, rcnt_d;
  logic [3:0] ridx;
  monitor_pkg::mon_state_e state_q, state_d;
  logic en_q, en_d, sst_q, sst_d;
  logic [3:0] sig_q, sig_d;

  tick_divider #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  // Bus: ack one cycle after the request, write lands on the ack edge
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_comb begin
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    dat_d = dat_q;
    if (ack_d) begin
      dat_d = 32'h00000000;
      case (wb_adr_i)
        `A_CTRL: begin
          dat_d[`CTRL_VAR] = var_q;
          dat_d[`CTRL_CONS_HI:`CTRL_CONS_LO] = cons_q;
          dat_d[`CTRL_INC] = inc_en_q;
        end
        `A_DELAY: dat_d[5:0] = delay_q;
        `A_DISC: dat_d[13:0] = disc_q;
        `A_PERM: dat_d[15:0] = perm_q;
        `A_INC: dat_d[15:0] = inc_q;
        `A_FMIN: dat_d[15:0] = fmin_q;
        `A_FMAX: dat_d[15:0] = fmax_q;
        `A_ACT: dat_d[15:1] = act_q;
        `A_STATUS: begin
          dat_d[`ST_ERR] = (state_q == monitor_pkg::ST_ERROR);
          dat_d[`ST_EN] = en_q;
          dat_d[`ST_SENS] = sst_q;
          dat_d[`ST_RNG_HI:`ST_RNG_LO] = sig_q;
        end
        `A_VALUE: dat_d[15:0] = pv;
        default: begin
          for (int c = 0; c < 2; c++) begin
            if (wb_adr_i == 8'(`A_GRAD0 + c * `A_CH_STRIDE))
              dat_d[15:0] = grad_q[c];
            if (wb_adr_i == 8'(`A_OFS0 + c * `A_CH_STRIDE))
              dat_d[15:0] = ofs_q[c];
          end
          for (int i = 1; i < 16; i++) begin
            if (wb_adr_i == 8'(`A_RMIN0 + i * `A_R_STRIDE))
              dat_d[15:0] = rmin_q[i];
            if (wb_adr_i == 8'(`A_RMAX0 + i * `A_R_STRIDE))
              dat_d[15:0] = rmax_q[i];
          end
        end
      endcase
    end
  end

  always_comb begin
    var_d = var_q;
    cons_d = cons_q;
    inc_en_d = inc_en_q;
    delay_d = delay_q;
    disc_d = disc_q;
    perm_d = perm_q;
    inc_d = inc_q;
    fmin_d = fmin_q;
    fmax_d = fmax_q;
    act_d = act_q;
    if (wr && wb_sel_i[0]) begin
      case (wb_adr_i)
        `A_CTRL: begin
          var_d = wb_dat_i[`CTRL_VAR];
          cons_d = wb_dat_i[`CTRL_CONS_HI:`CTRL_CONS_LO];
          inc_en_d = wb_dat_i[`CTRL_INC];
        end
        `A_DELAY: delay_d = wb_dat_i[5:0];
        default: ;
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        `A_DISC: disc_d = 14'(wmerge(16'(disc_q), wb_dat_i, wb_sel_i));
        `A_PERM: perm_d = wmerge(perm_q, wb_dat_i, wb_sel_i);
        `A_INC: inc_d = wmerge(inc_q, wb_dat_i, wb_sel_i);
        `A_FMIN: fmin_d = wmerge(fmin_q, wb_dat_i, wb_sel_i);
        `A_FMAX: fmax_d = wmerge(fmax_q, wb_dat_i, wb_sel_i);
        `A_ACT: act_d = 15'(wmerge({act_q, 1'b0}, wb_dat_i, wb_sel_i) >> 1);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      var_q <= 1'b0;
      cons_q <= 3'h0;
      inc_en_q <= 1'b0;
      delay_q <= 6'h00;
      disc_q <= 14'h0000;
      perm_q <= 16'h0000;
      inc_q <= 16'h0000;
      fmin_q <= 16'h0000;
      fmax_q <= 16'h0000;
      act_q <= 15'h0000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      var_q <= var_d;
      cons_q <= cons_d;
      inc_en_q <= inc_en_d;
      delay_q <= delay_d;
      disc_q <= disc_d;
      perm_q <= perm_d;
      inc_q <= inc_d;
      fmin_q <= fmin_d;
      fmax_q <= fmax_d;
      act_q <= act_d;
    end
  end

  assign cur[0] = first_sensor_input_i;
  assign cur[1] = second_sensor_input_i;

  // Per channel: coefficients, standardization and current window
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [15:0] g_d, o_d;
    logic signed [32:0] prod;
    always_comb begin
      g_d = grad_q[c];
      o_d = ofs_q[c];
      if (wr && wb_adr_i == 8'(`A_GRAD0 + c * `A_CH_STRIDE))
        g_d = wmerge(grad_q[c], wb_dat_i, wb_sel_i);
      if (wr && wb_adr_i == 8'(`A_OFS0 + c * `A_CH_STRIDE))
        o_d = wmerge(ofs_q[c], wb_dat_i, wb_sel_i);
      // Both operands at full width so the product is never cut short
      prod = $signed({{17{grad_q[c][15]}}, grad_q[c]}) *
        $signed({17'h00000, cur[c]});
      norm[c] = 16'(prod >>> `GRAD_FRAC) + ofs_q[c];
      bad[c] = cur[c] < `SENS_MIN_UA || cur[c] > `SENS_MAX_UA;
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        grad_q[c] <= 16'h0000;
        ofs_q[c] <= 16'h0000;
      end else begin
        grad_q[c] <= g_d;
        ofs_q[c] <= o_d;
      end
    end
  end

  // Selectable process range table
  for (genvar i = 1; i < 16; i++) begin : g_rng
    logic [15:0] mn_d, mx_d;
    always_comb begin
      mn_d = rmin_q[i];
      mx_d = rmax_q[i];
      if (wr && wb_adr_i == 8'(`A_RMIN0 + i * `A_R_STRIDE))
        mn_d = wmerge(rmin_q[i], wb_dat_i, wb_sel_i);
      if (wr && wb_adr_i == 8'(`A_RMAX0 + i * `A_R_STRIDE))
        mx_d = wmerge(rmax_q[i], wb_dat_i, wb_sel_i);
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        rmin_q[i] <= 16'h0000;
        rmax_q[i] <= 16'h0000;
      end else begin
        rmin_q[i] <= mn_d;
        rmax_q[i] <= mx_d;
      end
    end
  end

  delay_line u_dly (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .delay_i(delay_q),
    .data_i(norm[0]),
    .data_o(v1)
  );
  assign v2 = norm[1];

  always_comb begin
    dsig = {v1[15], v1} - {v2[15], v2};
    adiff = dsig[16] ? 17'(-dsig) : 17'(dsig);
    over_perm = adiff > {1'b0, perm_q};
    below_perm = adiff < {1'b0, perm_q};
    inc_on = inc_en_q && disc_q != 14'h0000;
    over_inc = inc_on && adiff > {1'b0, inc_q};
    sens_ok = !bad[0] && !bad[1];
    five = 17'(disc_q) * `RST_MULT;
    if (disc_q == 14'h0000) begin
      rst_ticks = 14'(`RST_MAX_MS / `TICK_MS);
    end else if (five < 17'(`RST_MIN_MS / `TICK_MS)) begin
      rst_ticks = 14'(`RST_MIN_MS / `TICK_MS);
    end else if (five > 17'(`RST_MAX_MS / `TICK_MS)) begin
      rst_ticks = 14'(`RST_MAX_MS / `TICK_MS);
    end else begin
      rst_ticks = 14'(five);
    end
    case (monitor_pkg::cons_mode_e'(cons_q))
      monitor_pkg::CONS_FIRST: pv = v1;
      monitor_pkg::CONS_SECOND: pv = v2;
      monitor_pkg::CONS_MAX: pv = (v1 > v2) ? v1 : v2;
      monitor_pkg::CONS_MIN: pv = (v1 < v2) ? v1 : v2;
      monitor_pkg::CONS_AVG: pv = 16'(({v1[15], v1} + {v2[15], v2}) >>> 1);
      default: pv = v1;
    endcase
    // Fixed mode never looks at the selection code
    ridx = (range_sel_i == 4'h0) ? 4'h1 : range_sel_i;
    if (!var_q) begin
      cur_min = fmin_q;
      cur_max = fmax_q;
      rng_ok = 1'b1;
    end else begin
      cur_min = rmin_q[ridx];
      cur_max = rmax_q[ridx];
      rng_ok = range_sel_i != 4'h0 && act_q[ridx];
    end
    // An overrun of the increased difference must also hold off recovery
    near_ok = sens_ok && rng_ok && below_perm && !over_inc &&
      v1 >= cur_min && v1 <= cur_max &&
      v2 >= cur_min && v2 <= cur_max;
  end

  always_comb begin
    state_d = state_q;
    dcnt_d = dcnt_q;
    rcnt_d = rcnt_q;
    case (state_q)
      monitor_pkg::ST_NORMAL: begin
        if (tick) begin
          if (!sens_ok || over_inc ||
              (over_perm && (!inc_on || dcnt_q >= disc_q))) begin
            state_d = monitor_pkg::ST_ERROR;
            dcnt_d = 14'h0000;
          end else begin
            dcnt_d = over_perm ? dcnt_q + 14'h0001 : 14'h0000;
          end
        end
      end
      monitor_pkg::ST_ERROR: begin
        if (tick) begin
          if (!near_ok) begin
            rcnt_d = 14'h0000;
          end else if (rcnt_q + 14'h0001 >= rst_ticks) begin
            state_d = monitor_pkg::ST_NORMAL;
            rcnt_d = 14'h0000;
          end else begin
            rcnt_d = rcnt_q + 14'h0001;
          end
        end
      end
      default: state_d = monitor_pkg::ST_ERROR;
    endcase
    sst_d = state_q == monitor_pkg::ST_NORMAL && sens_ok;
    en_d = sst_d && rng_ok && pv >= cur_min && pv <= cur_max;
    sig_d = sst_d ? `SIG_RANGE_VALID : 4'h0;
  end

  // Start in error so outputs stay low until a full reset time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= monitor_pkg::ST_ERROR;
      dcnt_q <= 14'h0000;
      rcnt_q <= 14'h0000;
      en_q <= 1'b0;
      sst_q <= 1'b0;
      sig_q <= 4'h0;
    end else begin
      state_q <= state_d;
      dcnt_q <= dcnt_d;
      rcnt_q <= rcnt_d;
      en_q <= en_d;
      sst_q <= sst_d;
      sig_q <= sig_d;
    end
  end

  assign enable_o = en_q;
  assign sensor_status_o = sst_q;
  assign signal_range_o = sig_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_err_out;
    state_q == monitor_pkg::ST_ERROR |=>
      !enable_o && !sensor_status_o && signal_range_o == 4'h0;
  endproperty
  a_err_out: assert property (p_err_out)
    else $error("outputs not forced low in error");
  property p_bad_sensor;
    tick && !sens_ok |=> state_q == monitor_pkg::ST_ERROR;
  endproperty
  a_bad_sensor: assert property (p_bad_sensor)
    else $error("sensor fault did not enter error");
  property p_no_allow;
    tick && state_q == monitor_pkg::ST_NORMAL && over_perm && !inc_on
      |=> state_q == monitor_pkg::ST_ERROR;
  endproperty
  a_no_allow: assert property (p_no_allow)
    else $error("immediate discrepancy error missed");
  property p_disc_time;
    tick && state_q == monitor_pkg::ST_NORMAL && over_perm && inc_on &&
      dcnt_q >= disc_q |=> state_q == monitor_pkg::ST_ERROR;
  endproperty
  a_disc_time: assert property (p_disc_time)
    else $error("discrepancy time overrun missed");
  property p_inc;
    tick && over_inc |=> state_q == monitor_pkg::ST_ERROR;
  endproperty
  a_inc: assert property (p_inc)
    else $error("increased difference overrun missed");
  property p_recover;
    $past(state_q) == monitor_pkg::ST_ERROR &&
      state_q == monitor_pkg::ST_NORMAL |->
      $past(rcnt_q) + 14'h0001 >= $past(rst_ticks) && $past(near_ok);
  endproperty
  a_recover: assert property (p_recover)
    else $error("left error before reset time");
  property p_rst_time;
    disc_q == 14'h0000 ? rst_ticks == 14'(`RST_MAX_MS / `TICK_MS) :
      rst_ticks >= 14'(`RST_MIN_MS / `TICK_MS) &&
      rst_ticks <= 14'(`RST_MAX_MS / `TICK_MS);
  endproperty
  a_rst_time: assert property (p_rst_time)
    else $error("reset time out of bounds");
  property p_zero_sel;
    var_q && range_sel_i == 4'h0 |=> !enable_o;
  endproperty
  a_zero_sel: assert property (p_zero_sel)
    else $error("enable high with no range selected");
  property p_fixed;
    !var_q && state_q == monitor_pkg::ST_NORMAL && sens_ok &&
      pv >= cur_min && pv <= cur_max |=> enable_o;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed range enable not set");
  property p_bypass;
    delay_q == 6'h00 |-> v1 == norm[0];
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("zero delay not transparent");
  c_enter_err: cover property (state_q == monitor_pkg::ST_NORMAL ##1
    state_q == monitor_pkg::ST_ERROR);
  c_recover: cover property (state_q == monitor_pkg::ST_ERROR ##1
    state_q == monitor_pkg::ST_NORMAL);
  c_var_en: cover property (var_q && enable_o);
endmodule
`default_nettype wire

// *** inc/monitor_consts.svh ***
// Constants of the dual sensor plausibility monitor
`ifndef MONITOR_CONSTS_SVH
`define MONITOR_CONSTS_SVH

// Time base: evaluation tick in ms, clock in kHz
`define TICK_MS 4
`define CLK_KHZ 100000
`define TICK_CYC (`TICK_MS * `CLK_KHZ)

// Reset time limits, ms as printed, converted to ticks in the logic
`define RST_MIN_MS 1000
`define RST_MAX_MS 65532
`define RST_MULT 17'h00005

// Sensor current window in uA: 3.5 mA and 20.5 mA
`define SENS_MIN_UA 16'h0DAC
`define SENS_MAX_UA 16'h5014

// Gradient fixed point fraction bits
`define GRAD_FRAC 8

// Register byte offsets
`define A_CTRL 8'h00
`define A_DELAY 8'h04
`define A_DISC 8'h08
`define A_PERM 8'h0C
`define A_INC 8'h10
`define A_GRAD0 8'h14
`define A_OFS0 8'h18
`define A_CH_STRIDE 8'h08
`define A_FMIN 8'h24
`define A_FMAX 8'h28
`define A_ACT 8'h2C
`define A_STATUS 8'h30
`define A_VALUE 8'h34
`define A_RMIN0 8'h40
`define A_RMAX0 8'h44
`define A_R_STRIDE 8'h08

// Control register fields
`define CTRL_VAR 0
`define CTRL_CONS_LO 1
`define CTRL_CONS_HI 3
`define CTRL_INC 4

// Status register fields
`define ST_ERR 0
`define ST_EN 1
`define ST_SENS 2
`define ST_RNG_LO 4
`define ST_RNG_HI 7

// Signal range number reported while the value is valid
`define SIG_RANGE_VALID 4'h1

`endif

// *** inc/monitor_pkg.sv ***
// Types of the dual sensor plausibility monitor
package monitor_pkg;
  typedef logic signed [15:0] value_t;
  typedef enum logic [2:0] {
    CONS_FIRST, CONS_SECOND, CONS_MAX, CONS_MIN, CONS_AVG
  } cons_mode_e;
  typedef enum {ST_NORMAL, ST_ERROR} mon_state_e;
endpackage

// *** hdl/tick_divider.sv ***
// Divider giving the periodic evaluation tick
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
  parameter int TICK_CYCLES = 400000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  logic [19:0] cnt_q, cnt_d;

  always_comb begin
    if (cnt_q == 20'(TICK_CYCLES - 1)) begin
      cnt_d = 20'h00000;
    end else begin
      cnt_d = cnt_q + 20'h00001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 20'h00000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick_o = (cnt_q == 20'(TICK_CYCLES - 1));
endmodule
`default_nettype wire

// *** hdl/delay_line.sv ***
// Tick-stepped delay line for the first sensor value
`timescale 1ns/1ns
`default_nettype none
module delay_line (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic [5:0] delay_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o
);
  logic [5:0] wp_q, wp_d;
  logic [15:0] mem_q [64];

  always_comb begin
    wp_d = tick_i ? wp_q + 6'h01 : wp_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= 6'h00;
    end else begin
      wp_q <= wp_d;
    end
  end

  for (genvar e = 0; e < 64; e++) begin : g_ent
    logic [15:0] ent_d;
    always_comb begin
      ent_d = (tick_i && wp_q == 6'(e)) ? data_i : mem_q[e];
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mem_q[e] <= 16'h0000;
      end else begin
        mem_q[e] <= ent_d;
      end
    end
  end

  // Zero delay bypasses the ring so no tick of latency is added
  assign data_o = (delay_i == 6'h00) ? data_i : mem_q[wp_q - delay_i];
endmodule
`default_nettype wire

// *** tb/controller_model.sv ***
// Behavioural model of the controller logic that selects the process range
`timescale 1ns/1ns
`default_nettype none
module controller_model (
  input wire logic clk_i,
  input wire logic enable_i,
  input wire logic sensor_status_i,
  input wire logic [3:0] signal_range_i,
  output logic [3:0] range_sel_o,
  output logic approval_o
);
  initial range_sel_o = 4'h0;
  // Approval only with a valid signal range, never on enable alone
  assign approval_o = enable_i & sensor_status_i & (signal_range_i != 4'h0);
  // Four-bit code, changed just after an edge and then held
  task automatic select_range(input logic [3:0] code);
    @(posedge clk_i);
    range_sel_o <= code;
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking testbench of the plausibility monitor
`timescale 1ns/1ns
`default_nettype none
`include "monitor_consts.svh"
module testbench;
  localparam int TICK = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic [15:0] first_cur = 16'h2710;
  logic [15:0] second_cur = 16'h2710;
  logic [3:0] range_sel;
  logic [3:0] sig_range;
  logic enable;
  logic sens;
  logic approval;
  int error_cnt = 0;
  int comparisons = 0;
  logic [15:0] cons_exp [5] =
    '{16'h2710, 16'h274C, 16'h274C, 16'h2710, 16'h272E};

  always #5 clk_i = ~clk_i;

  plausibility_monitor #(.TICK_CYCLES(TICK)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .first_sensor_input_i(first_cur),
    .second_sensor_input_i(second_cur), .range_sel_i(range_sel),
    .enable_o(enable), .sensor_status_o(sens), .signal_range_o(sig_range));

  controller_model u_ctrl (
    .clk_i(clk_i), .enable_i(enable), .sensor_status_i(sens),
    .signal_range_i(sig_range), .range_sel_o(range_sel),
    .approval_o(approval));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Request held until ack is seen; no fixed latency assumed
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  task automatic done(input string name);
    $display("test %s finished at %0t", name, $time);
  endtask

  // Good inputs for a full reset time of 250 ticks plus margin
  task automatic recover();
    @(posedge clk_i);
    first_cur <= 16'h2710;
    second_cur <= 16'h2710;
    wr(`A_CTRL, 32'h18);
    cyc_wait(260 * TICK);
    check(32'(sens), 32'h1);
  endtask

  // Fault entry: error taken on a tick, all outputs forced low
  task automatic fault(input logic [31:0] ctrl, input logic [15:0] f,
                       input logic [15:0] s, input bit quiet);
    wr(`A_CTRL, ctrl);
    @(posedge clk_i);
    first_cur <= f;
    second_cur <= s;
    if (quiet) begin
      cyc_wait(9);
      check(32'(sens), 32'h1);
    end
    cyc_wait(30);
    check(32'({enable, sens, sig_range}), 32'h0);
    rd_chk(`A_STATUS, 32'h1);
    recover();
  endtask

  initial begin
    cyc_wait(40000);
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`A_CTRL, 32'h0);
    rd_chk(`A_STATUS, 32'h1);
    rd_chk(8'hFC, 32'h0);
    wr(`A_STATUS, 32'h0);
    rd_chk(`A_STATUS, 32'h1);
    wr(`A_GRAD0, 32'h100);
    wr(`A_GRAD0 + `A_CH_STRIDE, 32'h100);
    wr(`A_PERM, 32'h64);
    wr(`A_INC, 32'h1F4);
    wr(`A_DISC, 32'h1);
    wr(`A_CTRL, 32'h18);
    wr(`A_FMIN, 32'h1388);
    wr(`A_FMAX, 32'h3A98);
    rd_chk(`A_PERM, 32'h64);
    done("registers");
    // Short discrepancy time clamps reset time to 250 ticks
    cyc_wait(240 * TICK);
    rd_chk(`A_STATUS, 32'h1);
    cyc_wait(20 * TICK);
    rd_chk(`A_STATUS, 32'h16);
    check(32'(approval), 32'h1);
    done("recovery");
    @(posedge clk_i);
    second_cur <= 16'h274C;
    for (int m = 0; m < 5; m++) begin
      wr(`A_CTRL, 32'h10 | (32'(m) << 1));
      rd_chk(`A_VALUE, 32'(cons_exp[m]));
    end
    done("consolidation");
    wr(`A_CTRL, 32'h18);
    u_ctrl.select_range(4'h5);
    @(posedge clk_i);
    first_cur <= 16'h3A99;
    second_cur <= 16'h3A99;
    cyc_wait(4);
    check(32'({enable, sens}), 32'h1);
    @(posedge clk_i);
    first_cur <= 16'h3A98;
    second_cur <= 16'h3A98;
    cyc_wait(4);
    check(32'(enable), 32'h1);
    @(posedge clk_i);
    first_cur <= 16'h1387;
    second_cur <= 16'h1387;
    cyc_wait(4);
    check(32'(enable), 32'h0);
    @(posedge clk_i);
    first_cur <= 16'h5014;
    second_cur <= 16'h5014;
    cyc_wait(30);
    check(32'({enable, sens}), 32'h1);
    done("fixed range");
    @(posedge clk_i);
    first_cur <= 16'h2710;
    second_cur <= 16'h2710;
    wr(8'h50, 32'h1388);
    wr(8'h54, 32'h3A98);
    wr(`A_ACT, 32'h4);
    wr(`A_CTRL, 32'h19);
    u_ctrl.select_range(4'h2);
    cyc_wait(4);
    check(32'(enable), 32'h1);
    u_ctrl.select_range(4'h0);
    cyc_wait(4);
    check(32'(enable), 32'h0);
    u_ctrl.select_range(4'h3);
    cyc_wait(4);
    check(32'(enable), 32'h0);
    done("variable range");
    wr(`A_CTRL, 32'h10);
    wr(`A_DELAY, 32'h2);
    cyc_wait(4 * TICK);
    @(posedge clk_i);
    first_cur <= 16'h2738;
    rd_chk(`A_VALUE, 32'h2710);
    cyc_wait(4 * TICK);
    rd_chk(`A_VALUE, 32'h2738);
    wr(`A_DELAY, 32'h0);
    done("delay");
    fault(32'h18, 16'h2710, 16'h27D8, 1'b1);
    fault(32'h18, 16'h2710, 16'h2968, 1'b0);
    fault(32'h08, 16'h2710, 16'h27D8, 1'b0);
    fault(32'h18, 16'h0BB8, 16'h2710, 1'b0);
    fault(32'h18, 16'h5015, 16'h5015, 1'b0);
    done("faults");
    complete_run();
  end
endmodule
`default_nettype wire
